// file: pkg/packer_cfg.svh
// Purpose: Constants of the transport-layer sample packer.
// Assumes: Included by its bare name from the design files.
// Notes:   Mode codes are the link mode select values.
`ifndef PACKER_CFG_SVH
`define PACKER_CFG_SVH
`define SMP_W      12
`define SMP_PER_CH 10
`define CH_NUM     4
`define LANE_NUM   8
`define LANE_W     64
`define FIFO_DEPTH 4
`define MODE_W     4
`define MODE_0     4'h0
`define MODE_1     4'h1
`define MODE_2     4'h2
`define MODE_3     4'h3
`define MODE_4     4'h4
`define MODE_5     4'h5
`define MODE_6     4'h6
`define OCT_M0     4'h8
`define OCT_M2     4'h1
`define OCT_M3     4'h5
`define OCT_2B     4'h2
`define TAIL_W     4
`endif

// file: pkg/packer_pkg.sv
// Purpose: Types of the transport-layer sample packer.
// Assumes: Nothing.
// Notes:   Variant order matches the two-bit variant pin code.
package packer_pkg;
	typedef enum logic [1:0] {CH_SINGLE, CH_DUAL, CH_QUAD} variant_t;
	typedef logic [11:0] sample_t;
endpackage

// file: rtl/sample_fifo.sv
// Purpose: Frame buffer between sample source and packer.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Read data comes straight from the storage flops.
`timescale 1ns/100ps
`include "packer_cfg.svh"
module sample_fifo
#(
	parameter int WIDTH = 480,
	parameter int DEPTH = `FIFO_DEPTH
)
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    wr_ptr_nxt;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW-1:0]    rd_ptr_nxt;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_r];

	always_comb
	begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		cnt_nxt    = cnt_r;
		if (push)
			wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
		if (pop)
			rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
		case ({push, pop})
			2'h2: cnt_nxt = cnt_r + 1'b1;
			2'h1: cnt_nxt = cnt_r - 1'b1;
			default: cnt_nxt = cnt_r;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r    <= cnt_nxt;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end
endmodule

// file: rtl/sample_packer.sv
// Purpose: Maps converter samples into per-lane octet frames.
// Assumes: One clock mclk, asynchronous active-high reset rst.
// Notes:   Lane frames are left aligned, octet 0 in bits 63:56.
// Functional notes
// - Lane arrangement follows the link mode latched for each frame.
// - Every leftover padding position in a lane frame is zero.
// - Samples go onto lanes most significant bit first.
// - Sample index n rises with time within a channel's frame.
// - Mode 0 puts even samples on one lane, odd on next, zero tail.
// - Mode 0 lane pairs carry A, B, C, D; upper four quad only.
// - Mode 1 packs two samples per channel as nibble stream.
// - Modes 1 and 6 single variant zero the byte holding B0.
// - Mode 2 sends one 8-bit sample per lane per frame.
// - Mode 3 packs four 10-bit samples into five octets per lane.
// - Mode 4 packs first samples of A to D contiguously over two-octet lanes.
// - Mode 4 zeroes B0 nibble on single, C0 byte on dual.
// - Mode 5 pairs A and B on lane 0, C and D on lane 1.
// - Mode 6 uses the same arrangement as mode 1.
// - Only the lowest lanes are used; higher lanes are off.
`timescale 1ns/100ps
`include "packer_cfg.svh"
module sample_packer
#(
	parameter int DEPTH = `FIFO_DEPTH
)
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [3:0]  link_mode_select,
	input  wire logic [1:0]  chan_variant,
	input  wire logic [479:0] sample_data,
	input  wire logic        sample_valid,
	output logic             sample_ready,
	output logic             frame_valid,
	input  wire logic        frame_ready,
	output logic [63:0]      serial_lane_0,
	output logic [63:0]      serial_lane_1,
	output logic [63:0]      serial_lane_2,
	output logic [63:0]      serial_lane_3,
	output logic [63:0]      serial_lane_4,
	output logic [63:0]      serial_lane_5,
	output logic [63:0]      serial_lane_6,
	output logic [63:0]      serial_lane_7,
	output logic [7:0]       lane_enable,
	output logic [3:0]       frame_octets,
	output logic             mode_error
);
	localparam int FW = `CH_NUM * `SMP_PER_CH * `SMP_W;
	logic [`MODE_W-1:0]    mode_m_r;
	logic [`MODE_W-1:0]    mode_s_r;
	logic [1:0]            var_m_r;
	logic [1:0]            var_s_r;
	packer_pkg::variant_t  var_cur;
	logic [FW-1:0]         fifo_data;
	logic                  fifo_valid;
	logic                  fifo_ready;
	logic                  take;
	packer_pkg::sample_t   smp [`CH_NUM][`SMP_PER_CH];
	logic [`LANE_W-1:0]    lane_map [`LANE_NUM];
	logic [`LANE_NUM-1:0]  en_map;
	logic [3:0]            oct_map;
	logic [2:0]            nch;
	logic [47:0]           q48;
	logic [`LANE_W-1:0]    lane_r [`LANE_NUM];
	logic [`LANE_W-1:0]    lane_nxt [`LANE_NUM];
	logic                  valid_r;
	logic                  valid_nxt;
	logic [`MODE_W-1:0]    mode_r;
	logic [`MODE_W-1:0]    mode_nxt;
	packer_pkg::variant_t  var_r;
	packer_pkg::variant_t  var_nxt;
	logic [7:0]            en_r;
	logic [7:0]            en_nxt;
	logic [3:0]            oct_r;
	logic [3:0]            oct_nxt;
	logic                  err_r;
	logic                  err_nxt;
	packer_pkg::sample_t   a0_w;
	packer_pkg::sample_t   a1_w;

	function automatic logic [3:0] lanes_used(input logic [3:0] m,
		input packer_pkg::variant_t v);
		logic [3:0] ch;
		ch = (v == packer_pkg::CH_SINGLE) ? 4'h1 :
			(v == packer_pkg::CH_DUAL) ? 4'h2 : 4'h4;
		case (m)
			`MODE_0: return ch << 1;
			`MODE_1, `MODE_6: return (ch == 4'h1) ? 4'h2 :
				(ch == 4'h2) ? 4'h3 : 4'h6;
			`MODE_2, `MODE_3: return ch;
			`MODE_4: return (ch == 4'h4) ? 4'h3 : ch;
			`MODE_5: return (ch == 4'h4) ? 4'h2 : 4'h1;
			default: return 4'h0;
		endcase
	endfunction
	function automatic logic [3:0] octets_of(input logic [3:0] m);
		case (m)
			`MODE_0: return `OCT_M0;
			`MODE_2: return `OCT_M2;
			`MODE_3: return `OCT_M3;
			`MODE_1, `MODE_4, `MODE_5, `MODE_6: return `OCT_2B;
			default: return 4'h0;
		endcase
	endfunction

	sample_fifo
	#(.WIDTH (FW), .DEPTH (DEPTH))
	u_fifo
	(
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.in_data   (sample_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			mode_m_r <= '0;
			mode_s_r <= '0;
			var_m_r  <= '0;
			var_s_r  <= '0;
		end
		else
		begin
			mode_m_r <= link_mode_select;
			mode_s_r <= mode_m_r;
			var_m_r  <= chan_variant;
			var_s_r  <= var_m_r;
		end
	end

	assign var_cur = (var_s_r == 2'h3) ? packer_pkg::CH_QUAD :
		packer_pkg::variant_t'(var_s_r);
	assign nch = (var_cur == packer_pkg::CH_SINGLE) ? 3'h1 :
		(var_cur == packer_pkg::CH_DUAL) ? 3'h2 : 3'h4;
	assign fifo_ready = !valid_r || frame_ready;
	assign take = fifo_valid && fifo_ready;
	assign a0_w = smp[0][0];
	assign a1_w = smp[0][1];

	// Absent channels read as zero so their slots carry zero filler.
	always_comb
	begin
		for (int c = 0; c < `CH_NUM; c++)
			for (int n = 0; n < `SMP_PER_CH; n++)
				smp[c][n] = (c < int'(nch)) ?
					fifo_data[(c * `SMP_PER_CH + n) * `SMP_W +: `SMP_W] : '0;
	end

	always_comb
	begin
		q48 = '0;
		for (int i = 0; i < `LANE_NUM; i++)
			lane_map[i] = '0;
		case (mode_s_r)
			`MODE_0:
				for (int c = 0; c < `CH_NUM; c++)
				begin
					lane_map[2*c] = {smp[c][0], smp[c][2], smp[c][4],
						smp[c][6], smp[c][8], `TAIL_W'(0)};
					lane_map[2*c+1] = {smp[c][1], smp[c][3], smp[c][5],
						smp[c][7], smp[c][9], `TAIL_W'(0)};
				end
			`MODE_1, `MODE_6:
				for (int p = 0; p < 2; p++)
				begin
					q48 = {smp[2*p][0], smp[2*p][1],
						smp[2*p+1][0], smp[2*p+1][1]};
					lane_map[3*p]   = {q48[47:32], 48'h0};
					lane_map[3*p+1] = {q48[31:16], 48'h0};
					lane_map[3*p+2] = {q48[15:0], 48'h0};
				end
			`MODE_2:
				for (int c = 0; c < `CH_NUM; c++)
					lane_map[c] = {smp[c][0][7:0], 56'h0};
			`MODE_3:
				for (int c = 0; c < `CH_NUM; c++)
					lane_map[c] = {smp[c][0][9:0], smp[c][1][9:0],
						smp[c][2][9:0], smp[c][3][9:0], 24'h0};
			`MODE_4:
			begin
				q48 = {smp[0][0], smp[1][0], smp[2][0], smp[3][0]};
				lane_map[0] = {q48[47:32], 48'h0};
				lane_map[1] = {q48[31:16], 48'h0};
				lane_map[2] = {q48[15:0], 48'h0};
			end
			`MODE_5:
			begin
				lane_map[0] = {smp[0][0][7:0], smp[1][0][7:0], 48'h0};
				lane_map[1] = {smp[2][0][7:0], smp[3][0][7:0], 48'h0};
			end
			default:
				q48 = '0;
		endcase
		en_map = 8'((9'h1 << lanes_used(mode_s_r, var_cur)) - 9'h1);
		oct_map = octets_of(mode_s_r);
		for (int i = 0; i < `LANE_NUM; i++)
			if (!en_map[i])
				lane_map[i] = '0;
	end

	always_comb
	begin
		valid_nxt = valid_r;
		mode_nxt  = mode_r;
		var_nxt   = var_r;
		en_nxt    = en_r;
		oct_nxt   = oct_r;
		err_nxt   = err_r;
		for (int i = 0; i < `LANE_NUM; i++)
			lane_nxt[i] = lane_r[i];
		if (take)
		begin
			valid_nxt = 1'b1;
			mode_nxt  = mode_s_r;
			var_nxt   = var_cur;
			en_nxt    = en_map;
			oct_nxt   = oct_map;
			err_nxt   = (mode_s_r > `MODE_6);
			for (int i = 0; i < `LANE_NUM; i++)
				lane_nxt[i] = lane_map[i];
		end
		else if (frame_ready)
			valid_nxt = 1'b0;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			valid_r <= 1'b0;
			mode_r  <= '0;
			var_r   <= packer_pkg::CH_SINGLE;
			en_r    <= '0;
			oct_r   <= '0;
			err_r   <= 1'b0;
			for (int i = 0; i < `LANE_NUM; i++)
				lane_r[i] <= '0;
		end
		else
		begin
			valid_r <= valid_nxt;
			mode_r  <= mode_nxt;
			var_r   <= var_nxt;
			en_r    <= en_nxt;
			oct_r   <= oct_nxt;
			err_r   <= err_nxt;
			for (int i = 0; i < `LANE_NUM; i++)
				lane_r[i] <= lane_nxt[i];
		end
	end

	assign frame_valid   = valid_r;
	assign lane_enable   = en_r;
	assign frame_octets  = oct_r;
	assign mode_error    = err_r;
	assign serial_lane_0 = lane_r[0];
	assign serial_lane_1 = lane_r[1];
	assign serial_lane_2 = lane_r[2];
	assign serial_lane_3 = lane_r[3];
	assign serial_lane_4 = lane_r[4];
	assign serial_lane_5 = lane_r[5];
	assign serial_lane_6 = lane_r[6];
	assign serial_lane_7 = lane_r[7];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_m0_order;
		take && mode_s_r == `MODE_0 |=> serial_lane_0[63:52] == $past(a0_w)
			&& serial_lane_1[63:52] == $past(a1_w);
	endproperty
	a_m0_order: assert property (p_m0_order)
		else $error("Mode 0 lane pair does not hold A0 and A1 first.");
	property p_m0_tail;
		valid_r && mode_r == `MODE_0 |-> serial_lane_0[3:0] == 4'h0
			&& serial_lane_1[3:0] == 4'h0;
	endproperty
	a_m0_tail: assert property (p_m0_tail)
		else $error("Mode 0 tail bits are not zero.");
	property p_m1_stream;
		take && mode_s_r == `MODE_1 |=> serial_lane_0[63:52] == $past(a0_w)
			&& {serial_lane_0[51:48], serial_lane_1[63:56]} == $past(a1_w);
	endproperty
	a_m1_stream: assert property (p_m1_stream)
		else $error("Mode 1 nibble stream misplaces A0 or A1.");
	property p_single_b0;
		valid_r && (mode_r == `MODE_1 || mode_r == `MODE_6)
			&& var_r == packer_pkg::CH_SINGLE |-> serial_lane_1[55:48] == 8'h00;
	endproperty
	a_single_b0: assert property (p_single_b0)
		else $error("Single variant B0 byte is not zero.");
	property p_m2_octet;
		take && mode_s_r == `MODE_2 |=>
			{4'h0, serial_lane_0[63:56]} == ($past(a0_w) & 12'h0ff)
			&& frame_octets == `OCT_M2;
	endproperty
	a_m2_octet: assert property (p_m2_octet)
		else $error("Mode 2 lane 0 does not carry A0.");
	property p_m3_pack;
		take && mode_s_r == `MODE_3 |=>
			{2'h0, serial_lane_0[53:44]} == ($past(a1_w) & 12'h3ff)
			&& serial_lane_0[23:0] == 24'h0;
	endproperty
	a_m3_pack: assert property (p_m3_pack)
		else $error("Mode 3 second sample or padding is wrong.");
	property p_m4_single;
		valid_r && mode_r == `MODE_4 && var_r == packer_pkg::CH_SINGLE
			|-> serial_lane_0[51:48] == 4'h0 && lane_enable == 8'h01;
	endproperty
	a_m4_single: assert property (p_m4_single)
		else $error("Mode 4 single variant filler or lanes wrong.");
	property p_m5_single;
		valid_r && mode_r == `MODE_5 && var_r == packer_pkg::CH_SINGLE
			|-> serial_lane_0[55:48] == 8'h00 && serial_lane_1 == '0;
	endproperty
	a_m5_single: assert property (p_m5_single)
		else $error("Mode 5 single variant B0 or lane 1 not zero.");
	property p_unused_off;
		valid_r && mode_r == `MODE_0 && var_r == packer_pkg::CH_DUAL
			|-> lane_enable == 8'h0f && serial_lane_4 == '0;
	endproperty
	a_unused_off: assert property (p_unused_off)
		else $error("Mode 0 dual variant uses upper lanes.");
	property p_hold;
		valid_r && !frame_ready |=> valid_r && $stable(serial_lane_0)
			&& $stable(mode_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Frame changed while stalled.");
endmodule

// file: bench/frame_sink.sv
// Purpose: Receiving logic model that accepts lane frames.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Slow mode drops ready on every other cycle.
`timescale 1ns/100ps
module frame_sink
(
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         stall,
	input  wire logic         slow,
	input  wire logic         frame_valid,
	input  wire logic [524:0] frm,
	output logic              frame_ready,
	output logic              got,
	output logic      [524:0] cap
);
	logic tog_r;
	always @(negedge mclk or posedge rst)
	begin
		if (rst)
		begin
			tog_r <= 1'b0;
			frame_ready <= 1'b0;
		end
		else
		begin
			tog_r <= ~tog_r;
			frame_ready <= !stall && !(slow && tog_r);
		end
	end
	// Frames are taken whole, all lanes captured on one rising edge.
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			got <= 1'b0;
			cap <= 525'h0;
		end
		else
		begin
			got <= frame_valid && frame_ready;
			if (frame_valid && frame_ready)
			begin
				cap <= frm;
			end
		end
	end
endmodule

// file: bench/testbench.sv
// Purpose: Self-checking bench of the sample packer.
// Assumes: Sink model on the frame side.
// Notes:   Expected frames are rebuilt from the lane layouts.
`timescale 1ns/100ps
module testbench;
	logic         mclk = 1'b0;
	logic         rst = 1'b1;
	logic [3:0]   mode = 4'h0;
	logic [1:0]   variant = 2'h2;
	logic [479:0] sdata = 480'h0;
	logic         svalid = 1'b0;
	logic         stall = 1'b0;
	logic         slow = 1'b0;
	logic         sready, fvalid, fready, merr, got;
	logic [63:0]  l0, l1, l2, l3, l4, l5, l6, l7;
	logic [7:0]   lane_en;
	logic [3:0]   foct;
	logic [524:0] frm, cap;
	int           n_fail = 0;
	int           checks = 0;
	assign frm = {merr, foct, lane_en, l0, l1, l2, l3, l4, l5, l6, l7};
	always #25 mclk = ~mclk;
	sample_packer #(.DEPTH(4)) uut (.mclk(mclk), .rst(rst),
		.link_mode_select(mode), .chan_variant(variant),
		.sample_data(sdata), .sample_valid(svalid), .sample_ready(sready),
		.frame_valid(fvalid), .frame_ready(fready), .serial_lane_0(l0),
		.serial_lane_1(l1), .serial_lane_2(l2), .serial_lane_3(l3),
		.serial_lane_4(l4), .serial_lane_5(l5), .serial_lane_6(l6),
		.serial_lane_7(l7), .lane_enable(lane_en), .frame_octets(foct),
		.mode_error(merr));
	frame_sink sink (.mclk(mclk), .rst(rst), .stall(stall), .slow(slow),
		.frame_valid(fvalid), .frm(frm), .frame_ready(fready), .got(got),
		.cap(cap));
	function automatic logic [479:0] pat(input int b);
		logic [479:0] d;
		for (int k = 0; k < 40; k++)
			d[k*12 +: 12] = 12'(k * 37 + b * 11 + 5);
		return d;
	endfunction
	function automatic logic [524:0] exp_frame(input int m, input int v,
		input logic [479:0] d);
		logic [11:0] s [4][10];
		logic [63:0] r [8];
		logic [47:0] st;
		int          nl;
		int          lt [7][3];
		lt = '{'{2,4,8}, '{2,3,6}, '{1,2,4}, '{1,2,4}, '{1,2,3},
			'{1,1,2}, '{2,3,6}};
		nl = lt[m][v];
		for (int c = 0; c < 4; c++)
			for (int n = 0; n < 10; n++)
				s[c][n] = (c < (v == 0 ? 1 : v * 2)) ?
					d[(c*10+n)*12 +: 12] : 12'h0;
		for (int l = 0; l < 8; l++)
		begin
			case (m)
				0: r[l] = {s[l/2][l%2], s[l/2][l%2+2], s[l/2][l%2+4],
					s[l/2][l%2+6], s[l/2][l%2+8], 4'h0};
				2: r[l] = {s[l%4][0][7:0], 56'h0};
				3: r[l] = {s[l%4][0][9:0], s[l%4][1][9:0],
					s[l%4][2][9:0], s[l%4][3][9:0], 24'h0};
				4: begin
					st = {s[0][0], s[1][0], s[2][0], s[3][0]};
					r[l] = {st[47-16*(l%3) -: 16], 48'h0};
				end
				5: begin
					st = {16'h0, s[0][0][7:0], s[1][0][7:0], s[2][0][7:0],
						s[3][0][7:0]};
					r[l] = {st[31-16*(l%2) -: 16], 48'h0};
				end
				default: begin
					st = {s[(l/3)%2*2][0], s[(l/3)%2*2][1],
						s[(l/3)%2*2+1][0], s[(l/3)%2*2+1][1]};
					r[l] = {st[47-16*(l%3) -: 16], 48'h0};
				end
			endcase
			if (l >= nl)
				r[l] = 64'h0;
		end
		return {1'b0, 4'(m == 0 ? 8 : m == 2 ? 1 : m == 3 ? 5 : 2),
			8'((1 << nl) - 1), r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
	endfunction
	task automatic compare(input logic [524:0] seen, input logic [524:0] want);
		checks++;
		if (seen !== want)
		begin
			n_fail++;
			$display("ERROR %0t frame mismatch", $time);
		end
	endtask
	task automatic summarize;
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic push(input logic [479:0] d);
		int i;
		i = 0;
		@(negedge mclk);
		sdata = d;
		svalid = 1'b1;
		while (sready !== 1'b1 && i < 200)
		begin
			@(negedge mclk);
			i++;
		end
		if (sready !== 1'b1)
			n_fail++;
		@(posedge mclk);
	endtask
	task automatic idle;
		@(negedge mclk);
		svalid = 1'b0;
	endtask
	task automatic rx(input logic [524:0] want);
		int i;
		i = 0;
		do
		begin
			@(negedge mclk);
			i++;
		end
		while (got !== 1'b1 && i < 200);
		if (got !== 1'b1)
			n_fail++;
		compare(cap, want);
	endtask
	task automatic t_reset;
		@(negedge mclk);
		compare(525'({fvalid, sready, lane_en, foct, merr}), 525'h2000);
	endtask
	task automatic t_modes;
		logic [479:0] d;
		slow <= 1'b1;
		for (int m = 0; m < 7; m++)
			for (int v = 0; v < 3; v++)
			begin
				mode = 4'(m);
				variant = 2'(v);
				repeat (3) @(negedge mclk);
				d = pat(m * 3 + v);
				push(d);
				push(~d);
				idle;
				rx(exp_frame(m, v, d));
				rx(exp_frame(m, v, ~d));
			end
	endtask
	task automatic t_bad;
		mode = 4'h9;
		repeat (3) @(negedge mclk);
		push(pat(50));
		idle;
		rx({1'b1, 524'h0});
	endtask
	task automatic t_fifo;
		mode = 4'h0;
		variant = 2'h3;
		stall <= 1'b1;
		slow <= 1'b0;
		repeat (3) @(negedge mclk);
		for (int k = 0; k < 5; k++)
			push(pat(100 + k));
		@(negedge mclk);
		sdata = pat(105);
		repeat (2) @(negedge mclk);
		compare(525'(sready), 525'h0);
		stall <= 1'b0;
		slow <= 1'b1;
		fork
			begin
				push(pat(105));
				idle;
			end
			for (int k = 0; k < 6; k++)
				rx(exp_frame(0, 2, pat(100 + k)));
		join
	endtask
	initial
	begin
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst <= 1'b0;
		t_reset;
		t_modes;
		t_bad;
		t_fifo;
		summarize;
	end
	initial
	begin
		#2000000;
		n_fail++;
		summarize;
	end
endmodule
